// *** rtl/i2cs_top.sv ***
// stop trigger, status register and bus-line control of the two-wire unit
`timescale 1ns/100ps
`include "i2cs_regs.svh"

// Notes on behaviour
// - stop: data low, clock high, wait, release data
// - eighth-clock wait stop lands in ninth high
// - stop bit self-clears on listed events
// - stop bit always reads back zero
// - ninth-clock wait cancel ends transmit drive
// - status read-only, resets zero, read waits
// - master state set on start, cleared
// - arbitration loss sticky until status read
// - bit operation elsewhere clears arbitration loss
// - extension code flagged at eighth rise
// - address match flagged at eighth rise
// - direction flag gates transmit data drive
// - direction flag from start and direction bit
// - direction flag cleared on common events
// - ack detected at ninth clock rise
// - start detected until first data byte begins
// - stop detected until next address byte
// - disable stops operation, clears status
// - exit abandons transfer, releases lines
// - wait cancel releases wait, self-clears
// - timing bit picks eighth or ninth wait on data bytes
module i2cs_top
    import i2cs_pkg::*;
#(
    parameter int STOP_SETUP_CYCLES =
        (`I2CS_STOP_SETUP_NS + `I2CS_CLK_PERIOD_NS - 1) / `I2CS_CLK_PERIOD_NS
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        link_clock,
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe,
    input  wire logic        serial_data_pin_in,
    output logic             serial_data_pin_out,
    output logic             serial_data_pin_oe,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic        cpu_bit_op,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_read_valid,
    input  wire logic [6:0]  own_slave_address,
    input  wire logic        shift_output_latch,
    input  wire logic        start_generated,
    input  wire logic        arbitration_loss,
    output i2cs_ctrl_t       control,
    output i2cs_stat_t       bus_status,
    output logic             wait_active
);
    localparam int CW = $clog2(STOP_SETUP_CYCLES + 1);

    if (STOP_SETUP_CYCLES < 1) begin : g_bad_setup
        $error("i2cs_top: STOP_SETUP_CYCLES must be at least 1");
    end

    logic             ev_toggle, ev_tog_s, ev_tog_d, ev_fire, scl_hi;
    i2cs_event_t      ev_word;
    logic             ev_start_s, ev_stop_s, ev_rise_s, ev_fall_s;
    logic             en, exit_p, kill;
    logic             wr_ctrl, rd_ctrl, rd_stat, bitop_other, stat_pending;
    logic [3:0]       bit_cnt;
    logic             addr_phase, drive_en, wait_ninth;
    logic [7:0]       shift;
    logic [7:0]       rx_byte;
    logic             eighth_rise, ninth_rise, first_rise, is_ext, is_match;
    logic             master_state, arbitration_lost, extension_code_seen, address_match;
    logic             direction_flag, ack_detected, start_detected, stop_detected;
    i2cs_stop_state_t stop_state;
    logic [CW-1:0]    stop_cnt;
    logic             stop_release;

    i2cs_link u_link (
        .link_clock (link_clock),
        .rst        (rst),
        .scl_pin    (serial_clock_pin_in),
        .sda_pin    (serial_data_pin_in),
        .ev_toggle  (ev_toggle),
        .ev_word    (ev_word)
    );

    i2cs_sync #(.WIDTH(1)) u_ev_sync (
        .clock (clock),
        .rst   (rst),
        .d     (ev_toggle),
        .q     (ev_tog_s)
    );

    // clock level for the stop sequence
    i2cs_sync #(.WIDTH(1), .INIT(1'b1)) u_scl_sync (
        .clock (clock),
        .rst   (rst),
        .d     (serial_clock_pin_in),
        .q     (scl_hi)
    );

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ev_tog_d <= 1'b0;
        end else begin
            ev_tog_d <= ev_tog_s;
        end
    end

    // event word is stable long before its toggle arrives here
    assign ev_fire     = ev_tog_s ^ ev_tog_d;
    assign ev_start_s  = ev_fire && ev_word.kind == ev_start;
    assign ev_stop_s   = ev_fire && ev_word.kind == ev_stop;
    assign ev_rise_s   = ev_fire && ev_word.kind == ev_rise;
    assign ev_fall_s   = ev_fire && ev_word.kind == ev_fall;
    assign en          = control.unit_enable;
    assign exit_p      = control.communication_exit;
    assign kill        = !en || exit_p;
    assign wr_ctrl     = cpu_wr && cpu_addr == `I2CS_CTRL_ADDR;
    assign rd_ctrl     = cpu_rd && cpu_addr == `I2CS_CTRL_ADDR;
    assign rd_stat     = cpu_rd && cpu_addr == `I2CS_STAT_ADDR;
    assign bitop_other = cpu_bit_op && (cpu_wr || cpu_rd) && cpu_addr != `I2CS_STAT_ADDR;
    assign rx_byte     = {shift[6:0], ev_word.sda};
    assign eighth_rise = ev_rise_s && bit_cnt == `I2CS_CNT_BIT8;
    assign ninth_rise  = ev_rise_s && bit_cnt == `I2CS_CNT_BIT9;
    assign first_rise  = ev_rise_s && bit_cnt == `I2CS_CNT_FIRST;
    assign is_ext      = rx_byte[7:4] == `I2CS_EXT_LOW || rx_byte[7:4] == `I2CS_EXT_HIGH;
    assign is_match    = rx_byte[7:1] == own_slave_address;
    assign stop_release = stop_state == st_low && stop_cnt == '0;
    assign bus_status  = {master_state, arbitration_lost, extension_code_seen, address_match,
                          direction_flag, ack_detected, start_detected, stop_detected};

    // control register; writes win over same-cycle hardware clears
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            control <= `I2CS_CTRL_RESET;
        end else begin
            control.communication_exit <= 1'b0;
            control.wait_cancel        <= 1'b0;
            if (kill || arbitration_loss || ev_stop_s) begin
                control.stop_trigger <= 1'b0;
            end
            if (kill || arbitration_loss || start_generated) begin
                control.start_trigger <= 1'b0;
            end
            if (wr_ctrl) begin
                control <= i2cs_ctrl_t'(cpu_wdata);
            end
        end
    end

    // bit counter and address shifter
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            bit_cnt    <= `I2CS_CNT_FIRST;
            addr_phase <= 1'b0;
            shift      <= '0;
        end else if (kill || ev_stop_s) begin
            bit_cnt    <= `I2CS_CNT_FIRST;
            addr_phase <= 1'b0;
        end else if (ev_start_s) begin
            bit_cnt    <= `I2CS_CNT_FIRST;
            addr_phase <= 1'b1;
        end else if (ev_rise_s && bit_cnt != `I2CS_CNT_BYTE_END) begin
            shift   <= rx_byte;
            bit_cnt <= bit_cnt + 4'h1;
        end else if (ev_fall_s && bit_cnt == `I2CS_CNT_BYTE_END) begin
            bit_cnt    <= `I2CS_CNT_FIRST;
            addr_phase <= 1'b0;
        end
    end

    // wait point chosen by timing bit on data bytes; the address byte always waits at the ninth clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_active <= 1'b0;
            wait_ninth  <= 1'b0;
        end else if (kill || ev_start_s || ev_stop_s || control.wait_cancel || stop_release) begin
            wait_active <= 1'b0;
        end else if (ev_fall_s && bit_cnt == `I2CS_CNT_BYTE_END
                     && (addr_phase || control.wait_interrupt_timing)) begin
            wait_active <= 1'b1;
            wait_ninth  <= 1'b1;
        end else if (ev_fall_s && bit_cnt == `I2CS_CNT_BIT9 && !addr_phase
                     && !control.wait_interrupt_timing) begin
            wait_active <= 1'b1;
            wait_ninth  <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            master_state <= 1'b0;
        end else if (!en) begin
            master_state <= 1'b0;
        end else begin
            if (ev_stop_s || arbitration_loss || exit_p) begin
                master_state <= 1'b0;
            end
            if (start_generated) begin
                master_state <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arbitration_lost <= 1'b0;
        end else if (!en) begin
            arbitration_lost <= 1'b0;
        end else begin
            if (stat_pending || bitop_other) begin
                arbitration_lost <= 1'b0;
            end
            if (arbitration_loss) begin
                arbitration_lost <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            extension_code_seen <= 1'b0;
            address_match       <= 1'b0;
        end else if (!en) begin
            extension_code_seen <= 1'b0;
            address_match       <= 1'b0;
        end else begin
            if (ev_start_s || ev_stop_s || exit_p) begin
                extension_code_seen <= 1'b0;
                address_match       <= 1'b0;
            end
            if (eighth_rise && addr_phase && is_ext) begin
                extension_code_seen <= 1'b1;
            end
            if (eighth_rise && addr_phase && is_match) begin
                address_match <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            direction_flag <= 1'b0;
        end else if (!en) begin
            direction_flag <= 1'b0;
        end else begin
            if (ev_stop_s || exit_p || arbitration_loss
                || (control.wait_cancel && wait_active && wait_ninth)
                || (ev_start_s && !master_state)) begin
                direction_flag <= 1'b0;
            end
            if (eighth_rise && addr_phase && master_state) begin
                direction_flag <= !ev_word.sda;
            end else if (eighth_rise && addr_phase && (is_match || is_ext)) begin
                direction_flag <= ev_word.sda;
            end
            if (start_generated) begin
                direction_flag <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ack_detected   <= 1'b0;
            start_detected <= 1'b0;
            stop_detected  <= 1'b0;
        end else if (!en) begin
            ack_detected   <= 1'b0;
            start_detected <= 1'b0;
            stop_detected  <= 1'b0;
        end else begin
            if (ev_stop_s || first_rise || exit_p) begin
                ack_detected <= 1'b0;
            end
            if (ninth_rise && !ev_word.sda) begin
                ack_detected <= 1'b1;
            end
            if (ev_stop_s || (first_rise && !addr_phase) || exit_p) begin
                start_detected <= 1'b0;
            end
            if (ev_start_s) begin
                start_detected <= 1'b1;
            end
            if (first_rise && addr_phase) begin
                stop_detected <= 1'b0;
            end
            if (ev_stop_s) begin
                stop_detected <= 1'b1;
            end
        end
    end

    // stop sequence; a request in an eighth-clock wait lands in the ninth high
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stop_state <= st_idle;
            stop_cnt   <= '0;
        end else if (kill || arbitration_loss) begin
            stop_state <= st_idle;
        end else begin
            unique case (stop_state)
                st_idle: begin
                    if (control.stop_trigger) begin
                        stop_state <= st_low;
                        stop_cnt   <= CW'(STOP_SETUP_CYCLES - 1);
                    end
                end
                st_low: begin
                    if (stop_cnt == '0) begin
                        stop_state <= st_scl;
                    end else begin
                        stop_cnt <= stop_cnt - CW'(1);
                    end
                end
                st_scl: begin
                    if (scl_hi) begin
                        stop_state <= st_hold;
                        stop_cnt   <= CW'(STOP_SETUP_CYCLES - 1);
                    end
                end
                st_hold: begin
                    if (stop_cnt == '0) begin
                        stop_state <= st_release;
                    end else begin
                        stop_cnt <= stop_cnt - CW'(1);
                    end
                end
                st_release: begin
                    if (!control.stop_trigger) begin
                        stop_state <= st_idle;
                    end
                end
            endcase
        end
    end

    // transmit drive starts at the first byte's ninth falling edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            drive_en <= 1'b0;
        end else if (kill || ev_start_s || ev_stop_s || !direction_flag) begin
            drive_en <= 1'b0;
        end else if (ev_fall_s && bit_cnt == `I2CS_CNT_BYTE_END && addr_phase) begin
            drive_en <= 1'b1;
        end
    end

    // lines released whenever disabled or exiting
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            serial_clock_pin_out <= 1'b0;
            serial_data_pin_out  <= 1'b0;
            serial_clock_pin_oe  <= 1'b0;
            serial_data_pin_oe   <= 1'b0;
        end else begin
            serial_clock_pin_out <= 1'b0;
            serial_data_pin_out  <= 1'b0;
            serial_clock_pin_oe  <= !kill && wait_active && !stop_release;
            serial_data_pin_oe   <= !kill && (stop_state inside {st_low, st_scl, st_hold}
                                    || (direction_flag && drive_en && !shift_output_latch));
        end
    end

    // register reads; status read spends one wait cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_rdata      <= `I2CS_STAT_RESET;
            cpu_read_valid <= 1'b0;
            stat_pending   <= 1'b0;
        end else begin
            cpu_read_valid <= 1'b0;
            stat_pending   <= rd_stat;
            if (rd_ctrl) begin
                cpu_rdata      <= control & `I2CS_CTRL_RD_MASK;
                cpu_read_valid <= 1'b1;
            end
            if (stat_pending) begin
                cpu_rdata      <= bus_status;
                cpu_read_valid <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    property p_stop_clear;
        ev_stop_s && !wr_ctrl |=> !control.stop_trigger;
    endproperty
    a_stop_clear: assert property (p_stop_clear)
        else $error("stop trigger survived stop detection");

    property p_ctrl_read_zero;
        rd_ctrl |=> cpu_read_valid && !cpu_rdata[0];
    endproperty
    a_ctrl_read_zero: assert property (p_ctrl_read_zero)
        else $error("stop trigger read back as one");

    property p_stat_wait;
        rd_stat |=> !cpu_read_valid ##1 (cpu_read_valid && cpu_rdata == $past(bus_status));
    endproperty
    a_stat_wait: assert property (p_stat_wait)
        else $error("status read without wait cycle or wrong data");

    property p_master_set;
        en && start_generated |=> master_state;
    endproperty
    a_master_set: assert property (p_master_set)
        else $error("master state not set on start");

    property p_arb_loss;
        en && arbitration_loss && !start_generated |=> arbitration_lost && !master_state;
    endproperty
    a_arb_loss: assert property (p_arb_loss)
        else $error("arbitration loss not recorded");

    property p_ext_code;
        en && eighth_rise && addr_phase && rx_byte[7:4] == `I2CS_EXT_HIGH |=> extension_code_seen;
    endproperty
    a_ext_code: assert property (p_ext_code)
        else $error("extension code not flagged");

    property p_ack;
        en && ninth_rise && !ev_word.sda |=> ack_detected;
    endproperty
    a_ack: assert property (p_ack)
        else $error("acknowledge not detected");

    property p_stop_drive;
        en && stop_state == st_low && !exit_p |=> serial_data_pin_oe;
    endproperty
    a_stop_drive: assert property (p_stop_drive)
        else $error("data line not held low during stop");

    property p_disable_clears;
        !en |=> bus_status == `I2CS_STAT_RESET && !serial_clock_pin_oe;
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("status not cleared while disabled");
endmodule

// *** common/i2cs_regs.svh ***
// register map, field values and timing constants of the two-wire stop/status block
`ifndef I2CS_REGS_SVH
`define I2CS_REGS_SVH

`define I2CS_CTRL_ADDR      16'hffa6
`define I2CS_STAT_ADDR      16'hffaa
`define I2CS_CTRL_RESET     8'h00
`define I2CS_STAT_RESET     8'h00
`define I2CS_CTRL_RD_MASK   8'hfc

`define I2CS_CNT_BIT8       4'h7
`define I2CS_CNT_BIT9       4'h8
`define I2CS_CNT_BYTE_END   4'h9
`define I2CS_CNT_FIRST      4'h0
`define I2CS_EXT_LOW        4'h0
`define I2CS_EXT_HIGH       4'hf

`define I2CS_CLK_PERIOD_NS  10
`define I2CS_STOP_SETUP_NS  5000

`endif

// *** common/i2cs_pkg.sv ***
// shared types of the two-wire stop/status block
package i2cs_pkg;
    typedef struct packed {
        logic unit_enable;
        logic communication_exit;
        logic wait_cancel;
        logic stop_int_enable;
        logic wait_interrupt_timing;
        logic ack_generate_enable;
        logic start_trigger;
        logic stop_trigger;
    } i2cs_ctrl_t;

    typedef struct packed {
        logic master_state;
        logic arbitration_lost;
        logic extension_code_seen;
        logic address_match;
        logic direction_flag;
        logic ack_detected;
        logic start_detected;
        logic stop_detected;
    } i2cs_stat_t;

    typedef enum logic [1:0] {ev_start, ev_stop, ev_rise, ev_fall} i2cs_ev_kind_t;

    typedef struct packed {
        i2cs_ev_kind_t kind;
        logic          sda;
    } i2cs_event_t;

    typedef enum logic [2:0] {st_idle, st_low, st_scl, st_hold, st_release} i2cs_stop_state_t;
endpackage

// *** rtl/i2cs_sync.sv ***
// two flip-flop level synchroniser
`timescale 1ns/100ps
module i2cs_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    if (WIDTH < 1) begin : g_bad_width
        $error("i2cs_sync: WIDTH must be at least 1");
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta <= INIT;
            q    <= INIT;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// *** rtl/i2cs_link.sv ***
// bus-line event detector on the link clock
`timescale 1ns/100ps
module i2cs_link
    import i2cs_pkg::*;
(
    input  wire logic  link_clock,
    input  wire logic  rst,
    input  wire logic  scl_pin,
    input  wire logic  sda_pin,
    output logic       ev_toggle,
    output i2cs_event_t ev_word
);
    logic [1:0]  pins;
    logic [1:0]  prev;
    logic        fire;
    i2cs_event_t next_word;

    i2cs_sync #(.WIDTH(2), .INIT(2'h3)) u_pin_sync (
        .clock (link_clock),
        .rst   (rst),
        .d     ({scl_pin, sda_pin}),
        .q     (pins)
    );

    always_ff @(posedge link_clock or posedge rst) begin
        if (rst) begin
            prev <= 2'h3;
        end else begin
            prev <= pins;
        end
    end

    // data edge while clock high is a start or a stop
    always_comb begin
        fire           = 1'b1;
        next_word.sda  = pins[0];
        next_word.kind = ev_rise;
        if (prev[1] && pins[1] && prev[0] && !pins[0]) begin
            next_word.kind = ev_start;
        end else if (prev[1] && pins[1] && !prev[0] && pins[0]) begin
            next_word.kind = ev_stop;
        end else if (!prev[1] && pins[1]) begin
            next_word.kind = ev_rise;
        end else if (prev[1] && !pins[1]) begin
            next_word.kind = ev_fall;
        end else begin
            fire = 1'b0;
        end
    end

    // the word is held until the next event so the far side reads it stable
    always_ff @(posedge link_clock or posedge rst) begin
        if (rst) begin
            ev_toggle <= 1'b0;
            ev_word   <= '0;
        end else if (fire) begin
            ev_toggle <= !ev_toggle;
            ev_word   <= next_word;
        end
    end

    property p_start_scl_high;
        @(posedge link_clock) disable iff (rst)
        (fire && next_word.kind == ev_start) |-> (pins[1] && prev[1]);
    endproperty
    a_start_scl_high: assert property (p_start_scl_high)
        else $error("start seen without clock high");

    property p_toggle_on_event;
        @(posedge link_clock) disable iff (rst)
        $changed(ev_toggle) |-> $past(fire) && ev_word == $past(next_word);
    endproperty
    a_toggle_on_event: assert property (p_toggle_on_event)
        else $error("event toggle moved without a bus event");
endmodule

// *** tb/i2cs_bus_model.sv ***
// far-side bus device: a master that frames starts, bytes and stops
`timescale 1ns/100ps
module i2cs_bus_model (
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    output logic      scl,
    output logic      sda
);
    logic scl_drv = 1'b1;
    logic sda_drv = 1'b1;
    // both lines pulled up: a released line reads high
    assign scl = scl_drv & ~scl_oe;
    assign sda = sda_drv & ~sda_oe;
    task automatic start();
        sda_drv = 1'b0;
        #200;
        scl_drv = 1'b0;
        #200;
    endtask
    // msb first, ninth bit is the acknowledge slot
    task automatic send(input logic [8:0] bits);
        for (int i = 8; i >= 0; i--) begin
            sda_drv = bits[i];
            #200;
            scl_drv = 1'b1;
            #200;
            scl_drv = 1'b0;
        end
        sda_drv = 1'b1;
        #200;
    endtask
    task automatic stop();
        sda_drv = 1'b0;
        #200;
        scl_drv = 1'b1;
        #200;
        sda_drv = 1'b1;
        #200;
    endtask
endmodule

// *** tb/test_i2cs_top.sv ***
// self-checking bench of the stop trigger and status block
`timescale 1ns/100ps
`include "i2cs_regs.svh"
module test_i2cs_top
    import i2cs_pkg::*;
;
    logic        clock, rst, link_clock, scl, sda, scl_oe, sda_oe;
    logic        wr, rd, bit_op, st_gen, arb, valid, wait_active;
    logic        latch, scl_out, sda_out;
    logic [15:0] addr;
    logic [7:0]  wdata, rdata, got;
    i2cs_ctrl_t  control;
    i2cs_stat_t  bus_status;
    int          miscompares, tests_run;
    i2cs_top #(.STOP_SETUP_CYCLES(4)) i_dut (.clock(clock), .rst(rst), .link_clock(link_clock),
        .serial_clock_pin_in(scl), .serial_clock_pin_out(scl_out), .serial_clock_pin_oe(scl_oe),
        .serial_data_pin_in(sda), .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe),
        .cpu_addr(addr), .cpu_wr(wr), .cpu_rd(rd), .cpu_bit_op(bit_op), .cpu_wdata(wdata),
        .cpu_rdata(rdata), .cpu_read_valid(valid), .own_slave_address(7'h35),
        .shift_output_latch(latch), .start_generated(st_gen), .arbitration_loss(arb),
        .control(control), .bus_status(bus_status), .wait_active(wait_active));
    i2cs_bus_model i_bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl(scl), .sda(sda));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        link_clock = 1'b0;
        #3;
        forever #7.5 link_clock = ~link_clock;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr8(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0);
        @(negedge clock);
        addr = a;
        wdata = d;
        bit_op = b;
        wr = 1'b1;
        @(negedge clock);
        wr = 1'b0;
        bit_op = 1'b0;
        repeat (3) @(negedge clock);
    endtask
    // no answer within three cycles leaves the data unknown
    task automatic rd8(input logic [15:0] a, output logic [7:0] d);
        @(negedge clock);
        addr = a;
        rd = 1'b1;
        @(negedge clock);
        rd = 1'b0;
        d = 8'hxx;
        repeat (3) begin
            if (valid === 1'b1) d = rdata;
            @(negedge clock);
        end
    endtask
    task automatic pulse(input logic lose);
        @(negedge clock);
        st_gen = ~lose;
        arb = lose;
        @(negedge clock);
        st_gen = 1'b0;
        arb = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #500000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {rst, wr, rd, bit_op, st_gen, arb, latch} = 7'h41;
        addr = 16'h0000;
        wdata = 8'h00;
        miscompares = 0;
        tests_run = 0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        rd8(`I2CS_STAT_ADDR, got);
        chk(got, `I2CS_STAT_RESET, "status reset");
        wr8(`I2CS_STAT_ADDR, 8'hff);
        rd8(`I2CS_STAT_ADDR, got);
        chk(got, 8'h00, "status written");
        rd8(16'hff00, got);
        chk(got, 8'hxx, "unmapped");
        wr8(`I2CS_CTRL_ADDR, 8'h88);
        i_bus.start();
        chk(bus_status, 8'h02, "start");
        i_bus.send({7'h35, 2'b10});
        chk(bus_status, 8'h1e, "address");
        chk({7'h00, wait_active}, 8'h01, "ninth wait");
        // latch low while transmitting must pull the data line
        latch = 1'b0;
        repeat (2) @(negedge clock);
        chk({6'h00, sda_oe, sda}, 8'h02, "transmit drive");
        latch = 1'b1;
        wr8(`I2CS_CTRL_ADDR, 8'ha8);
        chk(control, 8'h88, "cancel");
        chk(bus_status, 8'h16, "cancel status");
        i_bus.stop();
        chk(bus_status, 8'h01, "stop");
        i_bus.start();
        i_bus.send({7'h78, 2'b00});
        chk(bus_status, 8'h26, "extension");
        // status read taken inside the wait, where software may read it
        rd8(`I2CS_STAT_ADDR, got);
        chk(got, 8'h26, "wait read");
        wr8(`I2CS_CTRL_ADDR, 8'hc8);
        chk(bus_status, 8'h00, "exit status");
        chk(control, 8'h88, "exit cleared");
        chk({7'h00, wait_active}, 8'h00, "exit wait");
        i_bus.stop();
        pulse(1'b0);
        chk(bus_status, 8'h89, "master");
        pulse(1'b1);
        chk(bus_status, 8'h41, "lost");
        rd8(`I2CS_STAT_ADDR, got);
        chk(got, 8'h41, "lost read");
        chk(bus_status, 8'h01, "lost cleared");
        pulse(1'b0);
        pulse(1'b1);
        wr8(`I2CS_CTRL_ADDR, 8'h88, 1'b1);
        chk(bus_status, 8'h01, "bit op");
        pulse(1'b0);
        // one stop, alone, as master, no transfer
        wr8(`I2CS_CTRL_ADDR, 8'h89);
        rd8(`I2CS_CTRL_ADDR, got);
        chk(got, 8'h88, "trigger read");
        for (int i = 0; i < 50 && sda_oe !== 1'b1; i++) @(negedge clock);
        chk({7'h00, sda_oe}, 8'h01, "data low");
        if (sda_oe !== 1'b1) report_and_stop();
        chk({6'h00, scl_out, sda_out}, 8'h00, "driven levels");
        for (int i = 0; i < 300 && control.stop_trigger !== 1'b0; i++) @(negedge clock);
        if (control.stop_trigger !== 1'b0) begin
            miscompares++;
            report_and_stop();
        end
        repeat (10) @(negedge clock);
        chk({7'h00, sda}, 8'h01, "data high");
        chk(control, 8'h88, "trigger cleared");
        chk(bus_status, 8'h01, "stopped");
        wr8(`I2CS_CTRL_ADDR, 8'h00);
        chk(bus_status, 8'h00, "disabled");
        report_and_stop();
    end
endmodule
